// *** rtl/dsc_params.svh ***
// register offsets, field positions, reset values and bus codes of the receiver config bank
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// word indices; byte address is four times the index
`define DSC_IDX_DEMOD   10'h019
`define DSC_IDX_SYNC    10'h01A

// reset values
`define DSC_RST_DEMOD   8'h4D
`define DSC_RST_SYNC    8'h00

// bit 4 of demodulator_settings is reserved and never stored
`define DSC_DEMOD_WMASK 8'hEF

// demodulator_settings fields
`define DSC_USE_HI      7
`define DSC_USE_LO      6
`define DSC_FIX_BIT     5
`define DSC_RSV_BIT     4
`define DSC_RCV_HI      3
`define DSC_RCV_LO      2
`define DSC_SYN_HI      1
`define DSC_SYN_LO      0

// sync_and_min_length fields
`define DSC_SLEN_HI     7
`define DSC_SLEN_LO     6
`define DSC_MLEN_HI     5
`define DSC_MLEN_LO     0

// bus
`define DSC_ADDR_W      12
`define DSC_RESP_OKAY   2'h0
`define DSC_RESP_DECERR 2'h3

`endif

// *** rtl/dsc_pkg.sv ***
// types shared by the receiver configuration bank and its helpers
package dsc_pkg;

  // -------------------------------------------------------------
  // bus state machines
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP    = 2'h2
  } wr_state_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_RESP = 2'h2
  } rd_state_e;

  // -------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------
  typedef struct packed {
    logic use_i;
    logic use_q;
    logic combine;
  } chan_sel_s;

  typedef struct packed {
    wr_state_e   wst;
    rd_state_e   rst;
    logic        aw_got;
    logic        w_got;
    logic [9:0]  aw_idx;
    logic [7:0]  wdata;
    logic        wbyte;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic [7:0]  demod;
    logic [7:0]  sync;
    logic [1:0]  pll_tau;
    logic        pll_freeze;
  } bank_s;

endpackage : dsc_pkg

// *** rtl/dsc_chan_select.sv ***
// i/q channel choice for the demodulator, with per-communication freeze
`timescale 1ns/1ns
`include "dsc_params.svh"
module dsc_chan_select (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // configuration
  input  wire logic [1:0]        chan_use,
  input  wire logic              fixed_sel,
  // demodulator status
  input  wire logic              i_stronger,
  input  wire logic              comm_active,
  // choice
  output dsc_pkg::chan_sel_s     sel
);

  typedef struct packed {
    logic               held;
    logic               held_i;
    dsc_pkg::chan_sel_s sel;
  } chan_s;

  chan_s st_r;
  chan_s st_nxt;
  logic  pick_i;

  always_comb begin
    st_nxt = st_r;
    pick_i = i_stronger;
    // capture the stronger channel on the first cycle of a communication
    if (!comm_active) begin
      st_nxt.held = 1'b0;
    end else if (!st_r.held) begin
      st_nxt.held   = 1'b1;
      st_nxt.held_i = i_stronger;
    end
    st_nxt.sel.combine = 1'b0;
    if (fixed_sel) begin
      st_nxt.sel.use_i = ~chan_use[0]; // [RQ5]
      st_nxt.sel.use_q = chan_use[0]; // [RQ6]
    end else begin
      case (chan_use) // [RQ4]
        2'h1: begin
          if (st_r.held) begin
            pick_i = st_r.held_i; // [RQ2]
          end
        end
        2'h2: begin
          st_nxt.sel.combine = 1'b1; // [RQ3]
        end
        default: begin
          pick_i = i_stronger; // [RQ1]
        end
      endcase
      st_nxt.sel.use_i = pick_i | st_nxt.sel.combine;
      st_nxt.sel.use_q = ~pick_i | st_nxt.sel.combine;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sel = st_r.sel;

  property p_fix_q;
    @(posedge aclk) disable iff (!aresetn)
    (fixed_sel && chan_use[0]) |=> (sel.use_q && !sel.use_i && !sel.combine);
  endproperty
  a_fix_q: assert property (p_fix_q) // [RQ6]
    else $error("fixed q channel not selected");

  property p_freeze;
    @(posedge aclk) disable iff (!aresetn)
    (comm_active && $past(comm_active) && !fixed_sel && chan_use == 2'h1
     && $stable(chan_use) && $stable(fixed_sel)) |=> $stable(sel);
  endproperty
  a_freeze: assert property (p_freeze) // [RQ2]
    else $error("frozen channel choice changed during communication");

  property p_stronger;
    @(posedge aclk) disable iff (!aresetn)
    (!fixed_sel && chan_use == 2'h0) |=> (sel.use_i == $past(i_stronger));
  endproperty
  a_stronger: assert property (p_stronger) // [RQ1]
    else $error("stronger channel not followed");

endmodule : dsc_chan_select

// *** rtl/dsc_len_filter.sv ***
// minimum length check on received packets
`timescale 1ns/1ns
module dsc_len_filter (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // configuration
  input  wire logic [5:0]  min_len,
  input  wire logic        rate_106,
  input  wire logic        sync_detect,
  // packet end from the decoder
  input  wire logic        pkt_done,
  input  wire logic [8:0]  pkt_len,
  // verdict
  output logic             pkt_accept,
  output logic             pkt_discard
);

  typedef struct packed {
    logic accept;
    logic discard;
  } filt_s;

  filt_s st_r;
  filt_s st_nxt;
  logic  bypass;
  logic  long_enough;

  always_comb begin
    bypass         = rate_106 && !sync_detect; // [RQ13]
    long_enough    = pkt_len >= {1'b0, min_len, 2'h0}; // [RQ11]
    st_nxt.accept  = pkt_done && (bypass || long_enough);
    st_nxt.discard = pkt_done && !bypass && !long_enough; // [RQ12]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pkt_accept  = st_r.accept;
  assign pkt_discard = st_r.discard;

  property p_short;
    @(posedge aclk) disable iff (!aresetn)
    (pkt_done && !(rate_106 && !sync_detect) && pkt_len < {1'b0, min_len, 2'h0})
      |=> (pkt_discard && !pkt_accept);
  endproperty
  a_short: assert property (p_short) // [RQ12]
    else $error("short packet not discarded");

  property p_long;
    @(posedge aclk) disable iff (!aresetn)
    (pkt_done && pkt_len >= {1'b0, min_len, 2'h0}) |=> (pkt_accept && !pkt_discard);
  endproperty
  a_long: assert property (p_long) // [RQ11]
    else $error("long enough packet not accepted");

  property p_bypass;
    @(posedge aclk) disable iff (!aresetn)
    (pkt_done && rate_106 && !sync_detect) |=> pkt_accept;
  endproperty
  a_bypass: assert property (p_bypass) // [RQ13]
    else $error("length check not bypassed");

endmodule : dsc_len_filter

// *** rtl/dsc_cfg_bank.sv ***
// receiver configuration bank: axi4-lite slave, pll and sync controls, helpers
//
// Behaviour
// [RQ1] channel use 00: follow the stronger channel
// [RQ2] channel use 01: stronger, frozen for communication
// [RQ3] channel use 10: combine i and q
// [RQ4] channel-use codes apply only when fixed is 0
// [RQ5] fixed with low bit 0: i only
// [RQ6] fixed with low bit 1: q only
// [RQ7] receive tau selects pll during data reception
// [RQ8] receive tau 00 freezes pll in reception
// [RQ9] burst tau selects pll during burst
// [RQ10] sync length adds 0 to 3 zero bytes
// [RQ11] accept packet if length at least 4*min
// [RQ12] shorter packets are silently discarded
// [RQ13] no length check at 106k without sync detection
// [RQ14] reserved bit 4 reads zero, writes ignored
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dsc_params.svh"
module dsc_cfg_bank (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [`DSC_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [`DSC_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // receiver status, same clock domain
  input  wire logic                    i_stronger,
  input  wire logic                    comm_active,
  input  wire logic                    rx_data_phase,
  input  wire logic                    rate_106,
  input  wire logic                    sync_detection_mode,
  // packet end from the decoder
  input  wire logic                    pkt_done,
  input  wire logic [8:0]              pkt_len,
  // demodulator and pll controls
  output dsc_pkg::chan_sel_s           chan_sel,
  output logic [1:0]                   pll_tau,
  output logic                         pll_freeze,
  // sync preamble: number of zero bytes ahead of the two sync bytes
  output logic [1:0]                   sync_zero_bytes,
  // packet verdict
  output logic                         pkt_accept,
  output logic                         pkt_discard
);

  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  // bit 0: demodulator_settings, bit 1: sync_and_min_length
  function automatic logic [1:0] reg_hit(input logic [9:0] idx);
    reg_hit = {idx == `DSC_IDX_SYNC, idx == `DSC_IDX_DEMOD};
  endfunction : reg_hit

  localparam dsc_pkg::bank_s BANK_RST = '{
    wst:        dsc_pkg::WR_COLLECT,
    rst:        dsc_pkg::RD_IDLE,
    aw_got:     1'b0,
    w_got:      1'b0,
    aw_idx:     10'h000,
    wdata:      8'h00,
    wbyte:      1'b0,
    awready:    1'b0,
    wready:     1'b0,
    bvalid:     1'b0,
    bresp:      `DSC_RESP_OKAY,
    arready:    1'b0,
    rvalid:     1'b0,
    rresp:      `DSC_RESP_OKAY,
    rdata:      8'h00,
    demod:      `DSC_RST_DEMOD,
    sync:       `DSC_RST_SYNC,
    pll_tau:    2'h0,
    pll_freeze: 1'b0
  };

  dsc_pkg::bank_s st_r;
  dsc_pkg::bank_s st_nxt;
  logic [1:0]     wr_hit;
  logic [1:0]     rd_hit;
  logic [1:0]     tau_rcv;
  logic [1:0]     tau_sync;

  assign tau_rcv  = st_r.demod[`DSC_RCV_HI:`DSC_RCV_LO];
  assign tau_sync = st_r.demod[`DSC_SYN_HI:`DSC_SYN_LO];

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  // address and data are taken independently, so the master may offer
  // them in either order; the write lands only once both are held
  always_comb begin
    st_nxt = st_r;
    wr_hit = 2'h0;
    rd_hit = 2'h0;

    case (st_r.wst)
      dsc_pkg::WR_COLLECT: begin
        if (s_axi_awvalid && st_r.awready) begin
          st_nxt.aw_got = 1'b1;
          st_nxt.aw_idx = s_axi_awaddr[`DSC_ADDR_W-1:2];
        end
        if (s_axi_wvalid && st_r.wready) begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata[7:0];
          st_nxt.wbyte = s_axi_wstrb[0];
        end
        if (st_nxt.aw_got && st_nxt.w_got) begin
          wr_hit = reg_hit(st_nxt.aw_idx);
          if (wr_hit[0] && st_nxt.wbyte) begin
            st_nxt.demod = st_nxt.wdata & `DSC_DEMOD_WMASK; // [RQ14]
          end
          if (wr_hit[1] && st_nxt.wbyte) begin
            st_nxt.sync = st_nxt.wdata; // [RQ10]
          end
          st_nxt.bresp  = (wr_hit != 2'h0) ? `DSC_RESP_OKAY : `DSC_RESP_DECERR;
          st_nxt.bvalid = 1'b1;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.wst    = dsc_pkg::WR_RESP;
        end
      end
      dsc_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.wst    = dsc_pkg::WR_COLLECT;
        end
      end
      default: begin
        st_nxt.wst = dsc_pkg::WR_COLLECT;
      end
    endcase
    st_nxt.awready = (st_nxt.wst == dsc_pkg::WR_COLLECT) && !st_nxt.aw_got;
    st_nxt.wready  = (st_nxt.wst == dsc_pkg::WR_COLLECT) && !st_nxt.w_got;

    case (st_r.rst)
      dsc_pkg::RD_IDLE: begin
        if (s_axi_arvalid && st_r.arready) begin
          rd_hit       = reg_hit(s_axi_araddr[`DSC_ADDR_W-1:2]);
          st_nxt.rdata = ({8{rd_hit[0]}} & st_r.demod) | ({8{rd_hit[1]}} & st_r.sync);
          st_nxt.rresp = (rd_hit != 2'h0) ? `DSC_RESP_OKAY : `DSC_RESP_DECERR;
          st_nxt.rvalid = 1'b1;
          st_nxt.rst    = dsc_pkg::RD_RESP;
        end
      end
      dsc_pkg::RD_RESP: begin
        if (s_axi_rready) begin
          st_nxt.rvalid = 1'b0;
          st_nxt.rst    = dsc_pkg::RD_IDLE;
        end
      end
      default: begin
        st_nxt.rst = dsc_pkg::RD_IDLE;
      end
    endcase
    st_nxt.arready = (st_nxt.rst == dsc_pkg::RD_IDLE);

    // pll time constant follows the reception phase
    if (rx_data_phase) begin
      st_nxt.pll_tau    = tau_rcv; // [RQ7]
      st_nxt.pll_freeze = (tau_rcv == 2'h0); // [RQ8]
    end else begin
      st_nxt.pll_tau    = tau_sync; // [RQ9]
      st_nxt.pll_freeze = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= BANK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign s_axi_awready   = st_r.awready;
  assign s_axi_wready    = st_r.wready;
  assign s_axi_bresp     = st_r.bresp;
  assign s_axi_bvalid    = st_r.bvalid;
  assign s_axi_arready   = st_r.arready;
  assign s_axi_rdata     = {24'h000000, st_r.rdata};
  assign s_axi_rresp     = st_r.rresp;
  assign s_axi_rvalid    = st_r.rvalid;
  assign pll_tau         = st_r.pll_tau;
  assign pll_freeze      = st_r.pll_freeze;
  assign sync_zero_bytes = st_r.sync[`DSC_SLEN_HI:`DSC_SLEN_LO]; // [RQ10]

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // the freeze in channel mode 01 is kept inside the helper, so a
  // mode change mid-communication takes effect one cycle later, not at its end
  dsc_chan_select u_chan (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .chan_use    (st_r.demod[`DSC_USE_HI:`DSC_USE_LO]),
    .fixed_sel   (st_r.demod[`DSC_FIX_BIT]),
    .i_stronger  (i_stronger),
    .comm_active (comm_active),
    .sel         (chan_sel)
  );

  dsc_len_filter u_len (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .min_len     (st_r.sync[`DSC_MLEN_HI:`DSC_MLEN_LO]),
    .rate_106    (rate_106),
    .sync_detect (sync_detection_mode),
    .pkt_done    (pkt_done),
    .pkt_len     (pkt_len),
    .pkt_accept  (pkt_accept),
    .pkt_discard (pkt_discard)
  );

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_pll_freeze;
    @(posedge aclk) disable iff (!aresetn)
    (rx_data_phase && tau_rcv == 2'h0) |=> (pll_freeze && pll_tau == 2'h0);
  endproperty
  a_pll_freeze: assert property (p_pll_freeze) // [RQ8]
    else $error("pll not frozen during reception");

  property p_pll_rcv;
    @(posedge aclk) disable iff (!aresetn)
    rx_data_phase |=> (pll_tau == $past(tau_rcv));
  endproperty
  a_pll_rcv: assert property (p_pll_rcv) // [RQ7]
    else $error("receive time constant not applied");

  property p_pll_burst;
    @(posedge aclk) disable iff (!aresetn)
    !rx_data_phase |=> (pll_tau == $past(tau_sync) && !pll_freeze);
  endproperty
  a_pll_burst: assert property (p_pll_burst) // [RQ9]
    else $error("burst time constant not applied");

  property p_rsv_zero;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(s_axi_bvalid) && st_r.aw_idx == `DSC_IDX_DEMOD && st_r.wbyte)
      |-> (st_r.demod == (st_r.wdata & `DSC_DEMOD_WMASK) && !st_r.demod[`DSC_RSV_BIT]);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // [RQ14]
    else $error("demodulator write wrong or reserved bit stored");

  property p_sync_len;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(s_axi_bvalid) && st_r.aw_idx == `DSC_IDX_SYNC && st_r.wbyte)
      |-> (sync_zero_bytes == st_r.wdata[`DSC_SLEN_HI:`DSC_SLEN_LO]);
  endproperty
  a_sync_len: assert property (p_sync_len) // [RQ10]
    else $error("sync preamble length not taken from write");

  property p_combine;
    @(posedge aclk) disable iff (!aresetn)
    (!st_r.demod[`DSC_FIX_BIT] && st_r.demod[`DSC_USE_HI:`DSC_USE_LO] == 2'h2)
      |=> (chan_sel.combine && chan_sel.use_i && chan_sel.use_q);
  endproperty
  a_combine: assert property (p_combine) // [RQ3]
    else $error("i and q not combined");

  property p_fix_i;
    @(posedge aclk) disable iff (!aresetn)
    (st_r.demod[`DSC_FIX_BIT] && !st_r.demod[`DSC_USE_LO])
      |=> (chan_sel.use_i && !chan_sel.use_q && !chan_sel.combine);
  endproperty
  a_fix_i: assert property (p_fix_i) // [RQ5]
    else $error("fixed i channel not selected");

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before bready");

  property p_rdata_hold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed before rready");

endmodule : dsc_cfg_bank

// *** bench/rf_peer_model.sv ***
// behavioural far-side model: channel strength, communication and packet ends
`timescale 1ns/1ns
module rf_peer_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // requests from the bench
  input  wire logic        comm_req,
  input  wire logic        frame_req,
  input  wire logic [8:0]  frame_len,
  // toward the receiver
  output logic             i_stronger,
  output logic             comm_active,
  output logic             pkt_done,
  output logic [8:0]       pkt_len
);
  logic [7:0] fade_r;

  // strength wanders every cycle so a frozen choice is really put to the test
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fade_r      <= 8'hA5;
      comm_active <= 1'b0;
      pkt_done    <= 1'b0;
      pkt_len     <= 9'h000;
    end else begin
      fade_r      <= {fade_r[6:0], fade_r[7] ^ fade_r[5] ^ fade_r[4] ^ fade_r[3]};
      comm_active <= comm_req;
      pkt_done    <= frame_req;
      // length is only meaningful with the pulse; otherwise it churns
      pkt_len     <= frame_req ? frame_len : ~pkt_len;
    end
  end
  assign i_stronger = fade_r[0];
endmodule : rf_peer_model

// *** bench/dsc_cfg_bank_tb.sv ***
// self-checking bench for the receiver configuration bank
`timescale 1ns/1ns
module dsc_cfg_bank_tb;
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, pll_tau, sync_zero_bytes;
  logic        i_stronger, comm_active, rx_data_phase, rate_106, sync_det;
  logic        pkt_done, pkt_accept, pkt_discard, pll_freeze, i_str_q;
  logic        comm_req, frame_req;
  logic [8:0]  pkt_len, frame_len;
  dsc_pkg::chan_sel_s chan_sel;
  int          errors, samples_checked, seed, k;
  logic [7:0]  d, m;
  logic [1:0]  r;
  logic [31:0] v;

  dsc_cfg_bank dsc_cfg_bank_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .i_stronger(i_stronger), .comm_active(comm_active),
    .rx_data_phase(rx_data_phase), .rate_106(rate_106),
    .sync_detection_mode(sync_det), .pkt_done(pkt_done), .pkt_len(pkt_len),
    .chan_sel(chan_sel), .pll_tau(pll_tau), .pll_freeze(pll_freeze),
    .sync_zero_bytes(sync_zero_bytes), .pkt_accept(pkt_accept),
    .pkt_discard(pkt_discard));

  rf_peer_model rf_peer_model_inst (
    .aclk(aclk), .aresetn(aresetn), .comm_req(comm_req), .frame_req(frame_req),
    .frame_len(frame_len), .i_stronger(i_stronger), .comm_active(comm_active),
    .pkt_done(pkt_done), .pkt_len(pkt_len));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) i_str_q <= i_stronger;

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // --------------------------------------------------------------
  // bus master
  // --------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] dat, output logic [1:0] resp);
    logic aw, w;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, dat}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw = 1'b0;
    w  = 1'b0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w = 1'b1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  function automatic logic [2:0] exp_chan(input logic [7:0] dm, input logic istr);
    if (dm[5]) return dm[6] ? 3'h2 : 3'h4;
    if (dm[7:6] == 2'h2) return 3'h7;
    return istr ? 3'h4 : 3'h2;
  endfunction : exp_chan

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    seed = 32'h0474F6D8;
    aresetn = 1'b0; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'hF;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    rx_data_phase = 1'b0; rate_106 = 1'b0; sync_det = 1'b0; comm_req = 1'b0;
    frame_req = 1'b0; frame_len = 9'h000; errors = 0; samples_checked = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h064, v, r); chk("demod reset", 32'h4D, v);
    rd(12'h068, v, r); chk("sync reset", 32'h00, v);
    rd(12'h070, v, r); chk("unmapped resp", 32'h3, {30'h0, r});
    chk("unmapped data", 32'h0, v);
    wr(12'h064, 8'hFF, r);
    chk("write resp", 32'h0, {30'h0, r});
    rd(12'h064, v, r);
    chk("read resp", 32'h0, {30'h0, r});
    chk("reserved bit", 32'hEF, v);
    // an unmapped write must not land anywhere, a cleared strobe must not land either
    wr(12'h070, 8'h5A, r);
    chk("unmapped write resp", 32'h3, {30'h0, r});
    wstrb <= 4'h0;
    wr(12'h064, 8'h00, r);
    chk("masked write resp", 32'h0, {30'h0, r});
    wstrb <= 4'hF;
    rd(12'h064, v, r);
    chk("masked write", 32'hEF, v);
    $display("test registers done");
    // channel choice for every fixed/use combination
    for (k = 0; k < 8; k++) begin
      d = {k[1:0], k[2], 5'h0D};
      wr(12'h064, d, r);
      repeat (6) begin
        @(negedge aclk); chk("chan_sel", {29'h0, exp_chan(d, i_str_q)}, chan_sel);
      end
    end
    // frozen choice holds through a communication while strength wanders
    wr(12'h064, 8'h4D, r);
    @(posedge aclk) comm_req <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk) m = {5'h0, chan_sel};
    repeat (8) begin
      @(negedge aclk); chk("frozen chan", {24'h0, m}, chan_sel);
    end
    @(posedge aclk) comm_req <= 1'b0;
    $display("test channel done");
    // pll time constants in both phases
    repeat (12) begin
      d = 8'($random(seed));
      wr(12'h064, d, r);
      @(posedge aclk) rx_data_phase <= d[4];
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("pll_tau", d[4] ? d[3:2] : d[1:0], pll_tau);
      chk("pll_freeze", d[4] && d[3:2] == 2'h0, pll_freeze);
    end
    $display("test pll done");
    // sync preamble lengths and packet filter
    for (k = 0; k < 48; k++) begin
      d = 8'($random(seed));
      if (k < 4) d[7:6] = k[1:0];
      wr(12'h068, d, r);
      @(negedge aclk); chk("sync_zero_bytes", d[7:6], sync_zero_bytes);
      rd(12'h068, v, r);
      chk("sync readback", {24'h0, d}, v);
      v = $random(seed);
      @(posedge aclk);
      rate_106  <= v[20];
      sync_det  <= v[21];
      frame_req <= 1'b1;
      frame_len <= (k % 3 == 0) ? {1'b0, d[5:0], 2'h0} :
                   (k % 3 == 1) ? {1'b0, d[5:0], 2'h0} - 9'h001 : v[8:0];
      @(posedge aclk) frame_req <= 1'b0;
      @(posedge aclk);
      @(negedge aclk);
      chk("pkt_accept", frame_len >= {1'b0, d[5:0], 2'h0} || (rate_106 && !sync_det),
          pkt_accept);
      chk("pkt_discard", !(frame_len >= {1'b0, d[5:0], 2'h0} || (rate_106 && !sync_det)),
          pkt_discard);
    end
    $display("test sync and length done");
    conclude();
  end
endmodule : dsc_cfg_bank_tb
